// file: logic/port_f_pkg.sv
// Constants and carriers for the port F upper pin multiplexer
package port_f_pkg;
   // ------------------------------------------------------------
   // Register map (word offsets, byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_PIN_INPUT     = 4'h0;
   localparam logic [3:0] OFS_OUTPUT_LATCH  = 4'h4;
   localparam logic [3:0] OFS_DIRECTION     = 4'h8;
   localparam logic [3:0] OFS_SEGMENT_HIGH  = 4'hC;
   localparam int         ADDR_W            = 4;
   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam int         BIT_SIX           = 6;
   localparam int         BIT_SEVEN         = 7;
   localparam int         SEG_24_BIT        = 0;
   localparam int         SEG_25_BIT        = 1;
   localparam logic [7:0] IMPL_MASK         = 8'hFE;
   localparam logic [7:0] LATCH_RESET       = 8'h00;
   localparam logic [7:0] DIR_RESET         = 8'hFE;
   localparam logic [7:0] SEG_RESET         = 8'h00;
   localparam logic [1:0] ANALOG_RESET      = 2'h3;
   localparam logic [2:0] SYNC_RESET        = 3'h0;

   typedef enum {BUS_IDLE, BUS_ACK} bus_state_t;

   // Per-pin pad signals
   typedef struct packed {
      logic o;
      logic oe;
      logic seg;
   } pad_out_t;

   // Analog side of the pin pair
   typedef struct packed {
      logic chan_eleven;
      logic comp_one_inv;
      logic comp_one_a;
      logic chan_five;
   } analog_sel_t;
endpackage

// file: logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
module pin_sync (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic d,
   output      logic q
);
   import port_f_pkg::*;

   typedef struct packed {
      logic [2:0] sh;
      logic       q;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   // Stage 0 feeds only stage 1; stages 1 and 2 must agree
   always_comb begin
      state_next = state_reg;
      state_next.sh = {state_reg.sh[1:0], d};
      if (state_reg.sh[1] == state_reg.sh[2]) begin
         state_next.q = state_reg.sh[2];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign q = state_reg.q;
endmodule

// file: logic/port_f_upper.sv
// Port F pins six and seven: function mux and Wishbone registers
// Operation
// - Direction 0 on pin six drives latch bit, analog enable notwithstanding.
// - Direction 1 on pin six reads pin; reads low when analog enabled.
// - Reset selects pin six analog channel eleven and comparator inverting input.
// - Direction 1 lets pin six feed comparator one input A.
// - Enabled segment 24 or 25 overrides everything on its pin.
// - Direction 0 on pin seven drives latch bit regardless of analog.
// - Direction 1 on pin seven reads pin; disabled while analog enabled.
// - Reset selects pin seven analog channel five.
// - Don't-care functions ignore or override the direction bit.
// - Bit 0 of port, latch, direction reads zero; bits 7..1 map pins.
`timescale 1ns/10ps
module port_f_upper (
   input  wire logic              CLK,
   input  wire logic              RST,
   input  wire logic              CYC_I,
   input  wire logic              STB_I,
   input  wire logic              WE_I,
   input  wire logic [port_f_pkg::ADDR_W-1:0] ADR_I,
   input  wire logic [3:0]        SEL_I,
   input  wire logic [31:0]       DAT_I,
   output      logic [31:0]       DAT_O,
   output      logic              ACK_O,
   input  wire logic [7:1]        PIN_I,
   output      logic [7:1]        PIN_O,
   output      logic [7:1]        PIN_OE,
   input  wire logic              ANALOG_SIX_EN,
   input  wire logic              ANALOG_SEVEN_EN,
   output      port_f_pkg::pad_out_t PAD_SIX,
   output      port_f_pkg::pad_out_t PAD_SEVEN,
   output      port_f_pkg::analog_sel_t ANALOG_SEL,
   output      logic              SLAVE_SELECT_N
);
   import port_f_pkg::*;

   typedef struct packed {
      bus_state_t  bus;
      logic [31:0] rdata;
      logic [7:0]  latch;
      logic [7:0]  dir;
      logic [7:0]  seg;
      logic [1:0]  ana;
      logic [7:1]  pin_o;
      logic [7:1]  pin_oe;
      pad_out_t    pad6;
      pad_out_t    pad7;
      analog_sel_t asel;
      logic        ss_n;
   } top_state_t;

   typedef enum {ROLE_SEGMENT, ROLE_OUTPUT, ROLE_INPUT} pin_role_t;

   top_state_t state_reg;
   top_state_t state_next;
   logic [7:1] pin_sync_q;
   logic [7:0] port_read;
   logic       seg6;
   logic       seg7;
   logic       ana6;
   logic       ana7;
   logic       bus_take;
   logic       wr_req;
   logic       wr_port;
   logic       wr_latch;
   logic       wr_dir;
   logic       wr_seg;
   logic [7:0] read_byte;
   logic [7:0] latch_wdata;
   logic [7:0] dir_wdata;
   logic [7:0] seg_wdata;
   logic       in6_en;
   logic       in7_en;
   logic       ss_next;
   pin_role_t  role6;
   pin_role_t  role7;
   analog_sel_t asel_next;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 1; g <= 7; g++) begin : g_sync
         pin_sync u_sync (
            .CLK (CLK),
            .RST (RST),
            .d   (PIN_I[g]),
            .q   (pin_sync_q[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Function selection
   // ------------------------------------------------------------
   // Analog enable is the software-controlled level or the reset default
   assign ana6 = ANALOG_SIX_EN | state_reg.ana[0];
   assign ana7 = ANALOG_SEVEN_EN | state_reg.ana[1];
   assign seg6 = state_reg.seg[SEG_24_BIT];
   assign seg7 = state_reg.seg[SEG_25_BIT];

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Only the idle state takes a request, so a strobe still held
   // in the ack cycle is not taken again in that cycle
   always_comb begin
      bus_take = 1'b0;
      wr_req   = 1'b0;
      wr_port  = 1'b0;
      wr_latch = 1'b0;
      wr_dir   = 1'b0;
      wr_seg   = 1'b0;
      if (state_reg.bus == BUS_IDLE && CYC_I && STB_I) begin
         bus_take = 1'b1;
      end
      if (bus_take && WE_I && SEL_I[0]) begin
         wr_req = 1'b1;
      end
      if (wr_req) begin
         case (ADR_I)
            OFS_PIN_INPUT: begin
               wr_port = 1'b1;
            end
            OFS_OUTPUT_LATCH: begin
               wr_latch = 1'b1;
            end
            OFS_DIRECTION: begin
               wr_dir = 1'b1;
            end
            OFS_SEGMENT_HIGH: begin
               wr_seg = 1'b1;
            end
            default: begin
               wr_port = 1'b0;
            end
         endcase
      end
   end

   // Bit 0 is not implemented in the port registers
   assign latch_wdata = DAT_I[7:0] & IMPL_MASK;
   assign dir_wdata   = DAT_I[7:0] & IMPL_MASK;
   assign seg_wdata   = DAT_I[7:0];

   // ------------------------------------------------------------
   // Pin roles and input gating
   // ------------------------------------------------------------
   // Segment drive outranks the direction bit
   always_comb begin
      role6 = ROLE_INPUT;
      if (seg6) begin
         role6 = ROLE_SEGMENT;
      end else if (!state_reg.dir[BIT_SIX]) begin
         role6 = ROLE_OUTPUT;
      end
   end

   always_comb begin
      role7 = ROLE_INPUT;
      if (seg7) begin
         role7 = ROLE_SEGMENT;
      end else if (!state_reg.dir[BIT_SEVEN]) begin
         role7 = ROLE_OUTPUT;
      end
   end

   // Digital input buffer is off for analog or segment use
   assign in6_en = !ana6 && !seg6;
   assign in7_en = !ana7 && !seg7;

   always_comb begin
      port_read = {pin_sync_q, 1'b0} & IMPL_MASK;
      if (!in6_en) begin
         port_read[BIT_SIX] = 1'b0;
      end
      if (!in7_en) begin
         port_read[BIT_SEVEN] = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Reads never have side effects
   always_comb begin
      read_byte = 8'h00;
      case (ADR_I)
         OFS_PIN_INPUT: begin
            read_byte = port_read;
         end
         OFS_OUTPUT_LATCH: begin
            read_byte = state_reg.latch & IMPL_MASK;
         end
         OFS_DIRECTION: begin
            read_byte = state_reg.dir & IMPL_MASK;
         end
         OFS_SEGMENT_HIGH: begin
            read_byte = state_reg.seg;
         end
         default: begin
            read_byte = 8'h00;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Analog routing and slave select
   // ------------------------------------------------------------
   // Segment drive cuts the pin off from the analog side too
   always_comb begin
      asel_next              = '0;
      asel_next.chan_eleven  = ana6 & ~seg6;
      asel_next.comp_one_inv = ana6 & ~seg6;
      if (state_reg.dir[BIT_SIX] && ana6 && !seg6) begin
         asel_next.comp_one_a = 1'b1;
      end
      asel_next.chan_five    = ana7 & ~seg7;
   end

   // Slave select idles high unless pin seven is an input
   always_comb begin
      ss_next = 1'b1;
      if (state_reg.dir[BIT_SEVEN] && !seg7) begin
         ss_next = pin_sync_q[BIT_SEVEN];
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // Pins one to seven: latch drives when direction is 0, unless segment takes six or seven
      state_next.pin_o  = state_reg.latch[7:1];
      state_next.pin_oe = ~state_reg.dir[7:1];
      // Analog enable never blocks the output path
      case (role6)
         ROLE_SEGMENT: begin
            state_next.pad6 = '{o: 1'b0, oe: 1'b0, seg: 1'b1};
            state_next.pin_o[BIT_SIX]  = 1'b0;
            state_next.pin_oe[BIT_SIX] = 1'b0;
         end
         ROLE_OUTPUT: begin
            state_next.pad6.o   = state_reg.latch[BIT_SIX];
            state_next.pad6.oe  = 1'b1;
            state_next.pad6.seg = 1'b0;
         end
         default: begin
            state_next.pad6.o   = state_reg.latch[BIT_SIX];
            state_next.pad6.oe  = 1'b0;
            state_next.pad6.seg = 1'b0;
         end
      endcase
      case (role7)
         ROLE_SEGMENT: begin
            state_next.pad7 = '{o: 1'b0, oe: 1'b0, seg: 1'b1};
            state_next.pin_o[BIT_SEVEN]  = 1'b0;
            state_next.pin_oe[BIT_SEVEN] = 1'b0;
         end
         ROLE_OUTPUT: begin
            state_next.pad7.o   = state_reg.latch[BIT_SEVEN];
            state_next.pad7.oe  = 1'b1;
            state_next.pad7.seg = 1'b0;
         end
         default: begin
            state_next.pad7.o   = state_reg.latch[BIT_SEVEN];
            state_next.pad7.oe  = 1'b0;
            state_next.pad7.seg = 1'b0;
         end
      endcase
      state_next.asel = asel_next;
      state_next.ss_n = ss_next;

      // ---------------------------------------------------------
      // Wishbone classic slave, one wait state
      // ---------------------------------------------------------
      case (state_reg.bus)
         BUS_IDLE: begin
            if (bus_take) begin
               state_next.bus   = BUS_ACK;
               state_next.rdata = {24'h000000, read_byte};
            end
            if (wr_port || wr_latch) begin
               // Port writes land in the latch
               state_next.latch = latch_wdata;
            end
            if (wr_dir) begin
               state_next.dir = dir_wdata;
               // Reset analog default stands until direction written
               state_next.ana = 2'b00;
            end
            if (wr_seg) begin
               state_next.seg = seg_wdata;
            end
         end
         BUS_ACK: begin
            state_next.bus = BUS_IDLE;
         end
         default: begin
            state_next.bus = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_reg        <= '0;
         state_reg.bus    <= BUS_IDLE;
         state_reg.latch  <= LATCH_RESET;
         state_reg.dir    <= DIR_RESET;
         state_reg.seg    <= SEG_RESET;
         state_reg.ana    <= ANALOG_RESET;
         state_reg.ss_n   <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all straight from flip-flops
   // ------------------------------------------------------------
   assign DAT_O          = state_reg.rdata;
   assign ACK_O          = (state_reg.bus == BUS_ACK);
   assign PIN_O          = state_reg.pin_o;
   assign PIN_OE         = state_reg.pin_oe;
   assign PAD_SIX        = state_reg.pad6;
   assign PAD_SEVEN      = state_reg.pad7;
   assign ANALOG_SEL     = state_reg.asel;
   assign SLAVE_SELECT_N = state_reg.ss_n;
endmodule

// file: dv/port_f_upper_chk.sv
// Port-level assertions for the port F upper pin multiplexer
`timescale 1ns/10ps
module port_f_upper_chk
   import port_f_pkg::*;
(
   input wire logic                         CLK,
   input wire logic                         RST,
   input wire logic                         CYC_I,
   input wire logic                         STB_I,
   input wire logic                         WE_I,
   input wire logic [port_f_pkg::ADDR_W-1:0] ADR_I,
   input wire logic [3:0]                   SEL_I,
   input wire logic [31:0]                  DAT_I,
   input wire logic [31:0]                  DAT_O,
   input wire logic                         ACK_O,
   input wire port_f_pkg::pad_out_t         PAD_SIX,
   input wire port_f_pkg::pad_out_t         PAD_SEVEN
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // ------------------------------------------------------------
   // Bus handshake, read data and pad muxing
   // ------------------------------------------------------------
   sequence s_wr(logic [3:0] a);
      CYC_I && STB_I && WE_I && SEL_I[0] && ADR_I == a && !ACK_O;
   endsequence
   property p_ack;
      CYC_I && STB_I && !ACK_O |=> ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack late");
   property p_ack_pulse;
      ACK_O |=> !ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_hi_zero;
      ACK_O && !WE_I |-> DAT_O[31:8] == 24'h000000;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper lanes set");
   property p_bit0;
      ACK_O && !WE_I && ADR_I != OFS_SEGMENT_HIGH |-> !DAT_O[0];
   endproperty
   a_bit0: assert property (p_bit0) else $error("bit 0 set");
   property p_seg6;
      PAD_SIX.seg |-> !PAD_SIX.oe;
   endproperty
   a_seg6: assert property (p_seg6) else $error("six drives");
   property p_seg7;
      PAD_SEVEN.seg |-> !PAD_SEVEN.oe;
   endproperty
   a_seg7: assert property (p_seg7) else $error("seven drives");
   // Segment state is stable across a direction write, so sampling it late is safe
   property p_dir6;
      s_wr(OFS_DIRECTION) |=> ##1
         PAD_SIX.oe == (!$past(DAT_I[BIT_SIX], 2) && !PAD_SIX.seg);
   endproperty
   a_dir6: assert property (p_dir6) else $error("six enable");
   property p_lat7;
      s_wr(OFS_OUTPUT_LATCH) ##2 PAD_SEVEN.oe |->
         PAD_SEVEN.o == $past(DAT_I[BIT_SEVEN], 2);
   endproperty
   a_lat7: assert property (p_lat7) else $error("seven level");
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the port F upper pin multiplexer
`timescale 1ns/10ps
module tb_top;
   import port_f_pkg::*;
   logic        clk, rst, cyc, stb, we, ack, an6, an7, ss_n;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat, q;
   logic [7:1]  pin_i, pin_o, pin_oe;
   pad_out_t    p6, p7;
   analog_sel_t asel;
   int          n_mismatch, n_tests;

   port_f_upper dut (.CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb),
      .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat),
      .ACK_O(ack), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe),
      .ANALOG_SIX_EN(an6), .ANALOG_SEVEN_EN(an7), .PAD_SIX(p6),
      .PAD_SEVEN(p7), .ANALOG_SEL(asel), .SLAVE_SELECT_N(ss_n));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task tally_and_finish;
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Ack and read data are looked at mid cycle, where they are settled
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [7:0] d);
      int   n;
      logic seen;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      seen = (ack === 1'b1);
      q = rdat;
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      if (!seen) begin
         n_mismatch++;
         tally_and_finish;
      end else begin
         @(posedge clk);
      end
   endtask
   // Covers the pin synchroniser latency with margin
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk("analog_sel", asel, 32'hF);
      bus(OFS_DIRECTION, 1'b0, 8'h00);
      chk("direction", q, 32'hFE);
      bus(OFS_OUTPUT_LATCH, 1'b0, 8'h00);
      chk("latch", q, 32'h0);
      bus(4'h2, 1'b0, 8'h00);
      chk("unmapped", q, 32'h0);
   endtask
   task automatic t_out;
      an6 <= 1'b1;
      an7 <= 1'b1;
      bus(OFS_DIRECTION, 1'b1, 8'h01);
      bus(OFS_DIRECTION, 1'b0, 8'h00);
      chk("direction", q, 32'h0);
      bus(OFS_PIN_INPUT, 1'b1, 8'hC1);
      bus(OFS_OUTPUT_LATCH, 1'b0, 8'h00);
      chk("latch", q, 32'hC0);
      @(posedge clk);
      chk("pad six", p6, 32'h6);
      chk("pad seven", p7, 32'h6);
      chk("pin drive", pin_oe, 32'h7F);
      chk("pin level", pin_o, 32'h60);
      bus(OFS_OUTPUT_LATCH, 1'b1, 8'h00);
      @(posedge clk);
      chk("pad seven low", p7, 32'h2);
   endtask
   task automatic t_in;
      an6 <= 1'b0;
      an7 <= 1'b0;
      bus(OFS_DIRECTION, 1'b1, 8'hFE);
      settle;
      bus(OFS_PIN_INPUT, 1'b0, 8'h00);
      chk("port", q, 32'hFE);
      chk("select high", ss_n, 32'h1);
      pin_i <= 7'h3F;
      settle;
      bus(OFS_PIN_INPUT, 1'b0, 8'h00);
      chk("port", q, 32'h7E);
      chk("select low", ss_n, 32'h0);
      an6 <= 1'b1;
      an7 <= 1'b1;
      settle;
      bus(OFS_PIN_INPUT, 1'b0, 8'h00);
      chk("port analog", q, 32'h3E);
      chk("analog on", asel, 32'hF);
   endtask
   task automatic t_seg;
      bus(OFS_DIRECTION, 1'b1, 8'h00);
      bus(OFS_SEGMENT_HIGH, 1'b1, 8'h03);
      bus(OFS_SEGMENT_HIGH, 1'b0, 8'h00);
      chk("segments", q, 32'h3);
      @(posedge clk);
      chk("six segment", p6[1:0], 32'h1);
      chk("seven segment", p7[1:0], 32'h1);
      chk("pin drive seg", pin_oe, 32'h1F);
      bus(OFS_SEGMENT_HIGH, 1'b1, 8'h00);
      @(posedge clk);
      chk("six released", p6[1:0], 32'h2);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, cyc, stb, we, an6, an7} = 6'h20;
      {adr, sel, wdat, pin_i} = {4'h0, 4'h1, 32'h0, 7'h7F};
      n_mismatch = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset;
      t_out;
      t_in;
      t_seg;
      tally_and_finish;
   end
endmodule
bind port_f_upper port_f_upper_chk chk (.CLK(CLK), .RST(RST), .CYC_I(CYC_I),
   .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
   .DAT_O(DAT_O), .ACK_O(ACK_O), .PAD_SIX(PAD_SIX), .PAD_SEVEN(PAD_SEVEN));
